// ==== logic/ccd_seq_defines.svh ====
`ifndef CCD_SEQ_DEFINES_SVH
`define CCD_SEQ_DEFINES_SVH
// core clock period
`define CLK_PERIOD_NS 10
// least time in ns to whole core cycles, rounded up
`define CYC_CEIL(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// all-reset gate width in normal mode
`define CLEAR_NORM_NS 1000
`define CLEAR_NORM_CYC `CYC_CEIL(`CLEAR_NORM_NS)
// transfer gate width, also its overlap with hshift clock one
`define XFER_WIDTH_NS 2000
`define XFER_WIDTH_CYC `CYC_CEIL(`XFER_WIDTH_NS)
// hold time after the transfer gate falls; clock one stays high this long plus the first pixel high time
`define P1_HOLD_NS 100
`define P1_HOLD_CYC `CYC_CEIL(`P1_HOLD_NS)
// horizontal clock high time (typical figure), 50 percent duty
`define HCLK_HIGH_NS 100
`define HCLK_HIGH_CYC `CYC_CEIL(`HCLK_HIGH_NS)
`define PIX_CYC (2 * `HCLK_HIGH_CYC)
`define PIX_NS (`PIX_CYC * `CLK_PERIOD_NS)
// output reset gate high time (typical figure)
`define ORST_HIGH_NS 15
`define ORST_HIGH_CYC `CYC_CEIL(`ORST_HIGH_NS)
// idle and reset pin levels: clock two and summing gate high, the rest low
`define PINS_IDLE 8'h18
// pixels clocked per line
`define LINE_PIX_SHORT 2102
`define LINE_PIX_TALL 2160
// least time in ns to whole pixel periods, rounded up
`define PIX_CEIL(ns) (((ns) + `PIX_NS - 1) / `PIX_NS)
// least integration and resistive-gate transfer times
`define INTEG_MIN_SHORT_NS 5000
`define INTEG_MIN_TALL_NS 100000
`define REGTR_MIN_SHORT_NS 5000
`define REGTR_MIN_TALL_NS 100000
`endif

// ==== logic/ccd_seq_pkg.sv ====
package ccd_seq_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_CLEAR, ST_TRANSFER, ST_HOLD, ST_READ, ST_DUMMY
   } state_type;
   // line setup, sampled at each line start
   typedef struct packed {
      logic shutter_mode;    // electronic shutter on
      logic tall_pixel;      // tall-pixel sensor variant
      logic [15:0] dummy_pulses; // dummy readout pixel count
   } line_cfg_type;
   // sensor drive pins
   typedef struct packed {
      logic all_reset_gate;
      logic transfer_gate;
      logic hshift_clock_one;
      logic hshift_clock_two;
      logic summing_gate;
      logic output_reset_gate;
      logic resistive_gate_high;
      logic resistive_gate_low;
   } ccd_pins_type;
endpackage

// ==== logic/linear_ccd_clock_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccd_seq_defines.svh"
module linear_ccd_clock_sequencer
   import ccd_seq_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic ENABLE,
   input wire line_cfg_type LINE_CFG,
   output var ccd_pins_type CCD_PINS,
   output logic LINE_START,
   output logic BUSY
);
   localparam logic [15:0] CLEAR_CYC = 16'(`CLEAR_NORM_CYC);
   localparam logic [15:0] XFER_CYC = 16'(`XFER_WIDTH_CYC);
   localparam logic [15:0] HOLD_CYC = 16'(`P1_HOLD_CYC);
   localparam logic [4:0] PIX_LAST = 5'(`PIX_CYC - 1);
   localparam logic [4:0] HIGH_CYC = 5'(`HCLK_HIGH_CYC);
   localparam logic [4:0] ORST_CYC = 5'(`ORST_HIGH_CYC);
   // assertion figures
   localparam int XFER_LEN = `XFER_WIDTH_CYC;
   localparam int CLEAR_LEN = `CLEAR_NORM_CYC;
   localparam int PIX_LEN = `PIX_CYC;
   // reset gate low span between two pulses, two cycles high per pixel
   localparam int ORST_GAP = `PIX_CYC - 2;

   state_type state_ff; // sequencer state
   state_type nxt_state;
   line_cfg_type cfg_ff; // setup of the running line
   logic [15:0] tmr_ff; // cycles in timed states
   logic [4:0] phase_ff; // cycle within a pixel period
   logic [15:0] pix_ff; // pixel within read or dummy part
   ccd_pins_type pins_ff; // registered pin levels
   ccd_pins_type nxt_pins;
   logic [15:0] line_pix; // pixels per line for the variant
   logic [15:0] min_pix; // least integration, in pixels
   logic [15:0] tr_pix; // least resistive transfer, in pixels
   logic [15:0] dummy_min; // floor on dummy count
   logic [15:0] dummy_eff; // dummy pixels actually clocked
   logic timer_done; // timed state complete
   logic pix_end; // last cycle of a pixel period
   logic part_end; // last cycle of read or dummy part

   // variant figures
   // integration floor by variant
   assign min_pix = cfg_ff.tall_pixel ? 16'(`PIX_CEIL(`INTEG_MIN_TALL_NS))
                                      : 16'(`PIX_CEIL(`INTEG_MIN_SHORT_NS));
   assign tr_pix = cfg_ff.tall_pixel ? 16'(`PIX_CEIL(`REGTR_MIN_TALL_NS))
                                     : 16'(`PIX_CEIL(`REGTR_MIN_SHORT_NS));
   assign line_pix = cfg_ff.tall_pixel ? 16'(`LINE_PIX_TALL) : 16'(`LINE_PIX_SHORT);
   // shutter mode needs room for both the pulse and the transfer after it
   assign dummy_min = cfg_ff.shutter_mode ? 16'(min_pix + tr_pix) : min_pix;
   // requested count sets integration, clamped to the floor
   assign dummy_eff = (cfg_ff.dummy_pulses > dummy_min) ? cfg_ff.dummy_pulses : dummy_min;

   assign timer_done = (state_ff == ST_CLEAR && tmr_ff == CLEAR_CYC - 16'h0001) ||
                       (state_ff == ST_TRANSFER && tmr_ff == XFER_CYC - 16'h0001) ||
                       (state_ff == ST_HOLD && tmr_ff == HOLD_CYC - 16'h0001);
   assign pix_end = (phase_ff == PIX_LAST);
   assign part_end = pix_end &&
      ((state_ff == ST_READ && pix_ff == line_pix - 16'h0001) ||
       (state_ff == ST_DUMMY && pix_ff == dummy_eff - 16'h0001));

   // next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         // normal mode clears the pixels once before the first line
         ST_IDLE: begin
            if (ENABLE) begin
               nxt_state = LINE_CFG.shutter_mode ? ST_TRANSFER : ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            if (timer_done) begin
               nxt_state = ST_TRANSFER;
            end
         end
         ST_TRANSFER: begin
            if (timer_done) begin
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (timer_done) begin
               nxt_state = ST_READ;
            end
         end
         ST_READ: begin
            if (part_end) begin
               nxt_state = ST_DUMMY;
            end
         end
         // a line always finishes before the sequencer stops
         ST_DUMMY: begin
            if (part_end) begin
               nxt_state = ENABLE ? ST_TRANSFER : ST_IDLE;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // line setup is taken only between lines so a line never changes shape
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         cfg_ff <= '0;
      end else if (state_ff == ST_IDLE || (state_ff == ST_DUMMY && part_end)) begin
         cfg_ff <= LINE_CFG;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         tmr_ff <= 16'h0000;
      end else if (timer_done || state_ff == ST_IDLE) begin
         tmr_ff <= 16'h0000;
      end else if (state_ff == ST_CLEAR || state_ff == ST_TRANSFER || state_ff == ST_HOLD) begin
         tmr_ff <= tmr_ff + 16'h0001;
      end
   end

   // pixel phase and pixel count through read and dummy parts
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         phase_ff <= 5'h00;
         pix_ff <= 16'h0000;
      end else if (state_ff == ST_READ || state_ff == ST_DUMMY) begin
         phase_ff <= pix_end ? 5'h00 : phase_ff + 5'h01;
         if (part_end) begin
            pix_ff <= 16'h0000;
         end else if (pix_end) begin
            pix_ff <= pix_ff + 16'h0001;
         end
      end else begin
         phase_ff <= 5'h00;
         pix_ff <= 16'h0000;
      end
   end

   // pin levels from state and counters
   always_comb begin
      nxt_pins = '0;
      // clocks run through the dummy part as well
      if (state_ff == ST_READ || state_ff == ST_DUMMY) begin
         nxt_pins.hshift_clock_one = (phase_ff < HIGH_CYC);
         // short reset pulse at each pixel start
         nxt_pins.output_reset_gate = (phase_ff < ORST_CYC);
      end else if (state_ff == ST_TRANSFER || state_ff == ST_HOLD) begin
         // clock one high across the whole transfer pulse
         nxt_pins.hshift_clock_one = 1'b1;
      end
      // clock two is the exact complement
      nxt_pins.hshift_clock_two = ~nxt_pins.hshift_clock_one;
      nxt_pins.summing_gate = nxt_pins.hshift_clock_two;
      // transfer gate for the timed transfer state
      nxt_pins.transfer_gate = (state_ff == ST_TRANSFER);
      // timed pulse in normal mode; whole read part in shutter mode
      nxt_pins.all_reset_gate = (state_ff == ST_CLEAR) ||
                                (state_ff == ST_READ && cfg_ff.shutter_mode);
      // pulse stops one transfer time before the transfer gate
      if (state_ff == ST_DUMMY && cfg_ff.shutter_mode && pix_ff < dummy_eff - tr_pix) begin
         nxt_pins.resistive_gate_high = 1'b1;
         nxt_pins.resistive_gate_low = 1'b1;
      end
   end

   // registered pins
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         // idle levels, not all zero: both clocks low at once would break
         pins_ff <= ccd_pins_type'(`PINS_IDLE);
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   assign CCD_PINS = pins_ff;
   // line start marks the cycle before the state enters transfer, two cycles before the transfer gate pin rises
   assign LINE_START = (state_ff != ST_TRANSFER) && (nxt_state == ST_TRANSFER);
   assign BUSY = (state_ff != ST_IDLE);

   // helper counters for assertions
   logic [31:0] xfer_len_ff; // cycles transfer gate has been high
   logic [31:0] clear_len_ff; // cycles all-reset gate has been high
   logic [31:0] gap_ff; // cycles since resistive pulse ended
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         xfer_len_ff <= 32'h00000000;
         clear_len_ff <= 32'h00000000;
         gap_ff <= 32'h00000000;
      end else begin
         xfer_len_ff <= pins_ff.transfer_gate ? xfer_len_ff + 32'h00000001 : 32'h00000000;
         clear_len_ff <= pins_ff.all_reset_gate ? clear_len_ff + 32'h00000001 : 32'h00000000;
         gap_ff <= pins_ff.resistive_gate_high ? 32'h00000000 : gap_ff + 32'h00000001;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   xfer_width_a: assert property ($fell(CCD_PINS.transfer_gate) |-> xfer_len_ff == XFER_LEN)
      else $error("transfer gate width wrong");
   xfer_overlap_a: assert property (CCD_PINS.transfer_gate |-> ##1 CCD_PINS.hshift_clock_one)
      else $error("clock one low around transfer gate");
   hclk_high_a: assert property (
      $rose(CCD_PINS.hshift_clock_one) |-> CCD_PINS.hshift_clock_one[*5])
      else $error("clock one high time too short");
   hclk_duty_a: assert property ((state_ff == ST_READ && $rose(CCD_PINS.hshift_clock_two) &&
      phase_ff != 5'h00) |-> CCD_PINS.hshift_clock_two[*8] ##1
      CCD_PINS.hshift_clock_two[*2] ##1 !CCD_PINS.hshift_clock_two)
      else $error("clock two duty off");
   hclk_comp_a: assert property (CCD_PINS.hshift_clock_one != CCD_PINS.hshift_clock_two)
      else $error("horizontal clocks not complementary");
   sum_copy_a: assert property (CCD_PINS.summing_gate == CCD_PINS.hshift_clock_two)
      else $error("summing gate differs from clock two");
   orst_pulse_a: assert property ($rose(CCD_PINS.output_reset_gate) |->
      CCD_PINS.output_reset_gate[*2] ##1 !CCD_PINS.output_reset_gate ##ORST_GAP
      CCD_PINS.output_reset_gate || !BUSY || state_ff == ST_TRANSFER ||
      state_ff == ST_HOLD)
      else $error("reset gate pulse shape wrong");
   clear_norm_a: assert property (($fell(CCD_PINS.all_reset_gate) && !cfg_ff.shutter_mode) |->
      clear_len_ff == CLEAR_LEN)
      else $error("normal all-reset pulse too short");
   clear_shut_a: assert property (($fell(CCD_PINS.all_reset_gate) && cfg_ff.shutter_mode) |->
      clear_len_ff == 32'(line_pix) * 32'(PIX_LEN))
      else $error("shutter all-reset shorter than a readout");
   reg_gap_a: assert property (($rose(CCD_PINS.transfer_gate) && cfg_ff.shutter_mode) |->
      gap_ff >= 32'(tr_pix) * 32'(PIX_LEN))
      else $error("resistive transfer time too short");
   dummy_clk_a: assert property ((state_ff == ST_DUMMY && phase_ff == 5'h00) |->
      ##1 CCD_PINS.output_reset_gate)
      else $error("pixel clocks stopped in dummy part");
endmodule // linear_ccd_clock_sequencer
`default_nettype wire

// ==== sim/ccd_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model
   import ccd_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire ccd_pins_type pins,
   output logic [7:0][31:0] hi_len,
   output logic [31:0] pix_cnt,
   output logic [31:0] reg_pix,
   output logic [31:0] viol
);
   logic [7:0] now_v; // pins as a plain vector
   logic [7:0] last_ff; // pins one edge ago
   logic [7:0][31:0] run_ff; // running high time of each pin
   logic clk2_rise; // one charge packet reaches the output
   assign now_v = pins;
   assign clk2_rise = now_v[4] & ~last_ff[4];
   // high time of each pin, latched when the pin falls
   always_ff @(posedge core_clk) begin
      last_ff <= now_v;
      for (int i = 0; i < 8; i++) begin
         run_ff[i] <= now_v[i] ? run_ff[i] + 1 : 32'h0;
         if (!rst_n) begin
            hi_len[i] <= 32'h0;
         end else if (last_ff[i] && !now_v[i]) begin
            hi_len[i] <= run_ff[i];
         end
      end
   end
   // charge merged to output
   // each clock two rise hands one packet to the amplifier; a transfer restarts the line
   always_ff @(posedge core_clk) begin
      if (!rst_n || (now_v[6] && !last_ff[6])) begin
         pix_cnt <= 32'h0;
      end else if (clk2_rise) begin
         pix_cnt <= pix_cnt + 1;
      end
   end
   // packets shifted since the resistive gates dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n || (last_ff[1] && !now_v[1])) begin
         reg_pix <= 32'h0;
      end else if (clk2_rise) begin
         reg_pix <= reg_pix + 1;
      end
   end
   // drive faults the sensor cannot tolerate: clocks not complementary, summing
   // gate apart from clock two, split resistive gates, transfer without clock one
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         viol <= 32'h0;
      end else if ((now_v[5] == now_v[4]) || (now_v[3] != now_v[4])
                   || (now_v[1] != now_v[0]) || (now_v[6] && !now_v[5])) begin
         viol <= viol + 1;
      end
   end
endmodule // ccd_sensor_model
`default_nettype wire

// ==== sim/linear_ccd_clock_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccd_seq_defines.svh"
// one comparison, counted, reported at once on a mismatch
`define CHK(name, exp, got) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %0d seen %0d", name, (exp), (got)); \
   end \
end
module linear_ccd_clock_sequencer_tb;
   import ccd_seq_pkg::*;
   logic core_clk = 1'b0; // 100 MHz core clock
   logic rst_n = 1'b0; // synchronous reset, active low
   logic enable = 1'b0; // run request
   line_cfg_type line_cfg = '0; // line setup
   ccd_pins_type ccd_pins; // sensor drive pins
   logic line_start; // line start pulse
   logic busy; // sequencer active
   logic [7:0][31:0] hi_len; // measured high times
   logic [31:0] pix_cnt; // packets since last transfer
   logic [31:0] reg_pix; // packets since resistive gates fell
   logic [31:0] viol; // drive faults seen by the sensor
   int errors = 0; // mismatches
   int n_tests = 0; // comparisons
   int n_starts = 0; // line start pulses seen
   // core clock
   always #5 core_clk = ~core_clk;
   linear_ccd_clock_sequencer dut_u (.CORE_CLK(core_clk), .RST_N(rst_n), .ENABLE(enable),
      .LINE_CFG(line_cfg), .CCD_PINS(ccd_pins), .LINE_START(line_start), .BUSY(busy));
   ccd_sensor_model sensor_u (.core_clk(core_clk), .rst_n(rst_n), .pins(ccd_pins),
      .hi_len(hi_len), .pix_cnt(pix_cnt), .reg_pix(reg_pix), .viol(viol));
   // line start is combinational, so count it at the falling edge where it has settled
   always @(negedge core_clk) begin
      if (line_start === 1'b1) begin
         n_starts++;
      end
   end
   // verdict and end of run
   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // wait for busy to reach a level, bounded well beyond one line
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 50000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CHK("busy wait", lvl, busy)
   endtask
   // start one line and ask the sequencer to stop at its end
   task automatic run_line(input line_cfg_type cfg);
      int starts0;
      starts0 = n_starts;
      line_cfg = cfg;
      enable = 1'b1;
      wait_busy(1'b1);
      enable = 1'b0;
      wait_busy(1'b0);
      repeat (4) @(posedge core_clk);
      #1;
      // exactly one line start announces the single transfer of the line
      `CHK("line starts", 1, n_starts - starts0)
   endtask
   // idle levels: clock two and summing gate high, the rest low
   task automatic test_reset();
      `CHK("idle pins", `PINS_IDLE, ccd_pins)
      `CHK("idle busy", 1'b0, busy)
   endtask
   // normal mode, dummy count one below the floor so it is raised
   task automatic test_normal();
      int floor_pix;
      floor_pix = `PIX_CEIL(`INTEG_MIN_SHORT_NS);
      run_line({1'b0, 1'b0, 16'(floor_pix - 1)});
      `CHK("clear width", `CLEAR_NORM_CYC, hi_len[7])
      `CHK("transfer width", `XFER_WIDTH_CYC, hi_len[6])
      `CHK("clk1 high", `HCLK_HIGH_CYC, hi_len[5])
      `CHK("clk2 high", `HCLK_HIGH_CYC, hi_len[4])
      `CHK("summing high", `HCLK_HIGH_CYC, hi_len[3])
      `CHK("out reset high", `ORST_HIGH_CYC, hi_len[2])
      `CHK("line pixels", `LINE_PIX_SHORT + floor_pix, pix_cnt)
      `CHK("drive faults", 0, viol)
   endtask
   // shutter mode, dummy count one below its floor
   task automatic test_shutter();
      int tr_pix;
      int floor_pix;
      tr_pix = `PIX_CEIL(`REGTR_MIN_SHORT_NS);
      floor_pix = `PIX_CEIL(`INTEG_MIN_SHORT_NS) + tr_pix;
      run_line({1'b1, 1'b0, 16'(floor_pix - 1)});
      `CHK("clear shutter", `LINE_PIX_SHORT * `PIX_CYC, hi_len[7])
      `CHK("reg width", (floor_pix - tr_pix) * `PIX_CYC, hi_len[1])
      `CHK("reg transfer", tr_pix, reg_pix)
      `CHK("line pixels", `LINE_PIX_SHORT + floor_pix, pix_cnt)
      `CHK("drive faults", 0, viol)
   endtask
   // main sequence: 6-cycle reset, then inputs change just after each edge
   initial begin
      repeat (6) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      test_reset();
      test_normal();
      test_shutter();
      end_of_test();
   end
   // watchdog: both lines take about 86100 cycles
   initial begin
      repeat (95000) @(posedge core_clk);
      errors++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule // linear_ccd_clock_sequencer_tb
`default_nettype wire
